/* File: rtl/host_port_pkg.sv */
// Shared constants and types of the host bus port
// Assumes a single core clock; host pins arrive unsynchronised
package host_port_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int MODE_W = 3;
    localparam int SYNC_STAGES = 2;

    // ****************************************
    // Strap decode
    // ****************************************
    localparam logic [2:0] MODE_SEL = 3'h7;
    localparam logic BUS_STATUS_SEL = 1'h1;
    localparam logic ENDIAN_BIG = 1'h1;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [1:0] BE_RST = 2'h0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CORE_CLK_NS = 25;
    localparam int HOST_CLK_NS = 200;
    localparam int HOST_CLK_CYCLES = HOST_CLK_NS / CORE_CLK_NS;

    // ****************************************
    // Port sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        S_IDLE,
        S_ARB,
        S_READ_HOLD,
        S_WRITE_HOLD
    } port_state_t;

endpackage : host_port_pkg

/* File: rtl/pin_sync_if.sv */
// Bundle between raw host pins and their synchronised copies
// Assumes one producer of raw levels and one synchroniser
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;

    modport src (output raw, input sync);
    modport syn (input raw, output sync);
endinterface : pin_sync_if

`default_nettype wire

/* File: rtl/pin_sync.sv */
// Multi-stage synchroniser for host pin levels
// Assumes inputs are levels that stay put for several core clocks
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1,
    parameter int STAGES = 2
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    pin_sync_if.syn pins
);

    if (STAGES < 2 || W < 1) begin : g_bad_param
        $error("pin_sync needs at least two stages and one bit");
    end

    logic [W-1:0] stage_q [STAGES];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage_q[0] <= '0;
        end else begin
            stage_q[0] <= pins.raw;
        end
    end

    // ****************************************
    // Later stages
    // ****************************************
    for (genvar i = 1; i < STAGES; i++) begin : g_stage
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                stage_q[i] <= '0;
            end else begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign pins.sync = stage_q[STAGES-1];

endmodule : pin_sync

`default_nettype wire

/* File: rtl/host_bus_port.sv */
// Sixteen-bit host bus port with hold-off and refresh arbitration
// Assumes a core-side arbiter that acknowledges one access per request
//
// Operation
// - Transfers timed by host transfer clock edges
// - Data path to host is sixteen bits
// - Address and data pins pass through the two-stage pin synchroniser
// - Byte order taken from endian strap
// - Upper byte enable qualifies reads and writes
// - Write accepted only while write strobe low
// - Read data returned while read strobe low
// - Hold-off marks read ready, write accepted
// - Host waits while refresh owns resource
// - Hold-off output is active low
// - Bus status, direction inputs ignored in transfers
// - Low ready inserts waits; host extends cycle
// - Straps and bus status latched once the settle count reaches STRAP_SETTLE after reset release
`timescale 1ns/1ps
`default_nettype none

module host_bus_port (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic host_transfer_clock_i,
    input wire logic panel_ctrl_select_n_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    input wire logic upper_byte_enable_n_i,
    input wire logic bus_status_strap_i,
    input wire logic rd_wr_dir_i,
    input wire logic endian_strap_i,
    input wire logic [host_port_pkg::MODE_W-1:0] mode_strap_i,
    input wire logic [host_port_pkg::ADDR_W-1:0] address_inputs_i,
    input wire logic [host_port_pkg::DATA_W-1:0] data_lines_i,
    output logic [host_port_pkg::DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_n_o,
    output logic hold_off_n_o,
    input wire logic refresh_busy_i,
    input wire logic acc_ack_i,
    input wire logic [host_port_pkg::DATA_W-1:0] acc_rdata_i,
    output logic acc_req_o,
    output logic acc_we_o,
    output logic [host_port_pkg::ADDR_W-1:0] acc_addr_o,
    output logic [host_port_pkg::DATA_W-1:0] acc_wdata_o,
    output logic [1:0] acc_be_o,
    output logic big_endian_o,
    output logic mode_ok_o
);

    localparam int AW = host_port_pkg::ADDR_W;
    localparam int DW = host_port_pkg::DATA_W;
    localparam int MW = host_port_pkg::MODE_W;
    localparam int SW = 7 + MW + AW + DW;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    pin_sync_if #(.W(SW)) pin_bus ();

    // Direction input is left out on purpose
    assign pin_bus.raw = {host_transfer_clock_i, panel_ctrl_select_n_i, write_strobe_n_i,
                          read_strobe_n_i, upper_byte_enable_n_i, bus_status_strap_i,
                          endian_strap_i, mode_strap_i, address_inputs_i, data_lines_i};

    pin_sync #(
        .W(SW),
        .STAGES(host_port_pkg::SYNC_STAGES)
    ) u_pin_sync (
        .clk_i(mclk_i),
        .rstn_i(rstn_i),
        .pins(pin_bus)
    );

    wire logic hclk_s = pin_bus.sync[SW-1];
    wire logic cs_n_s = pin_bus.sync[SW-2];
    wire logic wr_n_s = pin_bus.sync[SW-3];
    wire logic rd_n_s = pin_bus.sync[SW-4];
    wire logic ube_n_s = pin_bus.sync[SW-5];
    wire logic status_s = pin_bus.sync[SW-6];
    wire logic endian_s = pin_bus.sync[SW-7];
    wire logic [MW-1:0] mode_s = pin_bus.sync[AW+DW+MW-1:AW+DW];
    wire logic [AW-1:0] addr_s = pin_bus.sync[AW+DW-1:DW];
    wire logic [DW-1:0] data_s = pin_bus.sync[DW-1:0];

    function automatic logic [DW-1:0] swap16(input logic [DW-1:0] v, input logic big);
        swap16 = big ? {v[7:0], v[15:8]} : v;
    endfunction : swap16

    // ****************************************
    // Strap capture after reset release
    // ****************************************
    logic [1:0] strap_cnt_q;
    logic strap_done_q;
    logic big_q;
    logic mode_ok_q;

    wire logic strap_take = !strap_done_q && (strap_cnt_q == host_port_pkg::STRAP_SETTLE);
    wire logic mode_match = (mode_s == host_port_pkg::MODE_SEL) &&
                            (status_s == host_port_pkg::BUS_STATUS_SEL);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            big_q <= 1'b0;
            mode_ok_q <= 1'b0;
        end else if (strap_take) begin
            strap_done_q <= 1'b1;
            big_q <= (endian_s == host_port_pkg::ENDIAN_BIG);
            mode_ok_q <= mode_match;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
        end
    end

    // ****************************************
    // Host clock edge and access decode
    // ****************************************
    logic hclk_prev_q;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hclk_prev_q <= 1'b0;
        end else begin
            hclk_prev_q <= hclk_s;
        end
    end

    host_port_pkg::port_state_t state_q, state_d;

    wire logic hclk_rise = hclk_s && !hclk_prev_q;
    wire logic sel_wr = !cs_n_s && !wr_n_s;
    wire logic sel_rd = !cs_n_s && !rd_n_s;
    wire logic start = (state_q == host_port_pkg::S_IDLE) && hclk_rise && mode_ok_q &&
                       (sel_wr || sel_rd);
    wire logic grant_ok = !acc_req_o && !refresh_busy_i;
    wire logic done = acc_req_o && acc_ack_i;
    wire logic rd_end = cs_n_s || rd_n_s;
    wire logic wr_end = cs_n_s || wr_n_s;
    wire logic [1:0] be_pin = {!ube_n_s, !addr_s[0]};
    wire logic [1:0] be_lane = big_q ? {be_pin[0], be_pin[1]} : be_pin;

    // ****************************************
    // Sequencer
    // ****************************************
    logic req_d;
    logic we_d;
    logic hold_n_d;
    logic oe_n_d;
    logic [AW-1:0] addr_d;
    logic [DW-1:0] wdata_d;
    logic [DW-1:0] rdata_d;
    logic [1:0] be_d;

    always_comb begin
        state_d = state_q;
        req_d = acc_req_o;
        we_d = acc_we_o;
        hold_n_d = hold_off_n_o;
        oe_n_d = data_lines_oe_n_o;
        addr_d = acc_addr_o;
        wdata_d = acc_wdata_o;
        rdata_d = data_lines_o;
        be_d = acc_be_o;
        unique case (state_q)
            host_port_pkg::S_IDLE: begin
                if (start) begin
                    state_d = host_port_pkg::S_ARB;
                    hold_n_d = 1'b0;
                    we_d = sel_wr;
                    addr_d = addr_s;
                    wdata_d = swap16(data_s, big_q);
                    be_d = be_lane;
                end
            end
            host_port_pkg::S_ARB: begin
                if (grant_ok) begin
                    req_d = 1'b1;
                end
                if (done) begin
                    req_d = 1'b0;
                    hold_n_d = 1'b1;
                    if (acc_we_o) begin
                        state_d = host_port_pkg::S_WRITE_HOLD;
                    end else begin
                        state_d = host_port_pkg::S_READ_HOLD;
                        rdata_d = swap16(acc_rdata_i, big_q);
                        oe_n_d = 1'b0;
                    end
                end
            end
            host_port_pkg::S_READ_HOLD: begin
                if (rd_end) begin
                    oe_n_d = 1'b1;
                    state_d = host_port_pkg::S_IDLE;
                end
            end
            host_port_pkg::S_WRITE_HOLD: begin
                if (wr_end) begin
                    state_d = host_port_pkg::S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= host_port_pkg::S_IDLE;
            acc_req_o <= 1'b0;
            acc_we_o <= 1'b0;
            hold_off_n_o <= 1'b1;
            data_lines_oe_n_o <= 1'b1;
            acc_addr_o <= host_port_pkg::ADDR_RST;
            acc_wdata_o <= host_port_pkg::DATA_RST;
            data_lines_o <= host_port_pkg::DATA_RST;
            acc_be_o <= host_port_pkg::BE_RST;
        end else begin
            state_q <= state_d;
            acc_req_o <= req_d;
            acc_we_o <= we_d;
            hold_off_n_o <= hold_n_d;
            data_lines_oe_n_o <= oe_n_d;
            acc_addr_o <= addr_d;
            acc_wdata_o <= wdata_d;
            data_lines_o <= rdata_d;
            acc_be_o <= be_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            big_endian_o <= 1'b0;
            mode_ok_o <= 1'b0;
        end else begin
            big_endian_o <= big_q;
            mode_ok_o <= mode_ok_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_start;
        start;
    endsequence

    sequence s_done_read;
        done && !acc_we_o;
    endsequence

    a_wait_on_start: assert property (s_start |=> !hold_off_n_o)
        else $error("hold-off not asserted after access start");

    a_wait_until_ack: assert property (!hold_off_n_o && !done |=> !hold_off_n_o)
        else $error("hold-off released before acknowledge");

    a_release_on_ack: assert property (done |=> hold_off_n_o && !acc_req_o)
        else $error("hold-off not released after acknowledge");

    a_req_no_refresh: assert property ($rose(acc_req_o) |-> $past(!refresh_busy_i))
        else $error("request raised while refresh busy");

    a_write_strobe: assert property (s_start ##1 acc_we_o |-> $past(sel_wr))
        else $error("write taken without write strobe");

    a_read_drive: assert property (s_done_read |=> !data_lines_oe_n_o ##1 !data_lines_oe_n_o
                                   || $past(rd_end))
        else $error("read data not driven after acknowledge");

    a_read_float: assert property (state_q == host_port_pkg::S_READ_HOLD && rd_end
                                   |=> data_lines_oe_n_o && state_q == host_port_pkg::S_IDLE)
        else $error("data lines not floated after read end");

    a_mode_gate: assert property (!mode_ok_q |-> hold_off_n_o && !acc_req_o)
        else $error("access served with wrong strap mode");

    a_endian_write: assert property (s_start |=> acc_wdata_o ==
                                     swap16($past(data_s), big_q))
        else $error("write data byte order wrong");

    a_float_idle: assert property (state_q == host_port_pkg::S_IDLE |-> data_lines_oe_n_o)
        else $error("data lines driven while idle");

    a_hold_idle: assert property (state_q == host_port_pkg::S_IDLE |-> hold_off_n_o)
        else $error("hold-off asserted while idle");

    a_req_steady: assert property (acc_req_o && !acc_ack_i
                                   |=> acc_req_o && $stable(acc_addr_o))
        else $error("request dropped or moved before acknowledge");

endmodule : host_bus_port

`default_nettype wire

/* File: tb/host_model.sv */
// Host bus master model facing the port's host pins
// Assumes a free-running host clock and the core clock from the bench
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic mclk_i,
    input wire logic hclk_i,
    input wire logic hold_off_n_i,
    input wire logic oe_n_i,
    input wire logic [15:0] dout_i,
    output logic sel_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic ube_n_o,
    output logic [16:0] addr_o,
    output logic [15:0] din_o
);
    // ****************************************
    // Data wire and host transfers
    // ****************************************
    logic [15:0] hd = 16'h0000;
    logic hdrv = 1'b0;
    logic [15:0] last = 16'h0000;

    initial begin
        sel_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        ube_n_o = 1'b1;
        addr_o = 17'h00000;
    end
    // Released wire shows a pattern that changes every cycle
    assign din_o = !oe_n_i ? dout_i : (hdrv ? hd : ~last);
    always @(posedge mclk_i) begin
        last <= din_o;
    end

    task automatic access(input logic we, input logic [16:0] a, input logic [15:0] d,
                          input logic ube, output logic [15:0] q, output int w);
        w = 0;
        @(negedge hclk_i);
        @(negedge mclk_i);
        addr_o = a;
        ube_n_o = ube;
        hd = d;
        hdrv = we;
        sel_n_o = 1'b0;
        wr_n_o = !we;
        rd_n_o = we;
        @(posedge hclk_i);
        do begin
            @(posedge hclk_i);
            w++;
        end while (hold_off_n_i !== 1'b1 && w < 20);
        q = din_o;
        @(negedge hclk_i);
        @(negedge mclk_i);
        sel_n_o = 1'b1;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        hdrv = 1'b0;
    endtask : access
endmodule : host_model

`default_nettype wire

/* File: tb/generic_host_bus_port_test.sv */
// Self-checking bench for the host bus port
// Assumes the host model and a core responder built in here
`timescale 1ns/1ps
`default_nettype none

module generic_host_bus_port_test;
    // ****************************************
    // Signals, clocks, design and partner
    // ****************************************
    logic mclk = 0, hclk = 0, rstn = 0, status = 1, dir = 1, endian = 0, busy = 0, ack = 0;
    logic sel_n, wr_n, rd_n, ube_n, oe_n, hold_n, acc_req, acc_we, big, mode_ok, c_we;
    logic [2:0] mode = 3'h7;
    logic [16:0] addr, acc_addr, c_addr;
    logic [15:0] din, dout, rdata = 16'h0000, rd_word = 16'h0000, acc_wdata, c_wdata;
    logic [1:0] acc_be, c_be;
    int ack_lat = 0, cnt = 0, low_cnt, req_cnt, req_busy, err_count = 0, checked = 0;

    always #12.5 mclk = ~mclk;
    initial begin
        #37;
        forever #100 hclk = ~hclk;
    end

    host_bus_port uut (.mclk_i(mclk), .rstn_i(rstn), .host_transfer_clock_i(hclk),
        .panel_ctrl_select_n_i(sel_n), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
        .upper_byte_enable_n_i(ube_n), .bus_status_strap_i(status), .rd_wr_dir_i(dir),
        .endian_strap_i(endian), .mode_strap_i(mode), .address_inputs_i(addr),
        .data_lines_i(din), .data_lines_o(dout), .data_lines_oe_n_o(oe_n),
        .hold_off_n_o(hold_n), .refresh_busy_i(busy), .acc_ack_i(ack), .acc_rdata_i(rdata),
        .acc_req_o(acc_req), .acc_we_o(acc_we), .acc_addr_o(acc_addr),
        .acc_wdata_o(acc_wdata), .acc_be_o(acc_be), .big_endian_o(big), .mode_ok_o(mode_ok));

    host_model host (.mclk_i(mclk), .hclk_i(hclk), .hold_off_n_i(hold_n), .oe_n_i(oe_n),
        .dout_i(dout), .sel_n_o(sel_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .ube_n_o(ube_n),
        .addr_o(addr), .din_o(din));

    // Core side: acknowledge after ack_lat cycles, capture the request
    always @(negedge mclk) begin
        ack <= 1'b0;
        if (acc_req === 1'b1 && !ack) begin
            if (cnt >= ack_lat) begin
                ack <= 1'b1;
                rdata <= rd_word;
                cnt <= 0;
                {c_we, c_addr, c_wdata, c_be} <= {acc_we, acc_addr, acc_wdata, acc_be};
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
    always @(posedge mclk) begin
        if (hold_n === 1'b0) low_cnt++;
        if (acc_req === 1'b1) req_cnt++;
        if (acc_req === 1'b1 && busy) req_busy++;
    end

    // ****************************************
    // Checking helpers
    // ****************************************
    function automatic bit ck(input bit bad);
        checked++;
        return bad;
    endfunction : ck
    task automatic fail(input string msg);
        err_count++;
        $display("ERROR %0t %s", $time, msg);
    endtask : fail
    task automatic close_out;
        $display("Mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic do_reset(input logic [2:0] m, input logic b, input logic e);
        @(negedge mclk);
        {rstn, mode, status, endian} = {1'b0, m, b, e};
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        repeat (8) @(negedge mclk);
    endtask : do_reset
    task automatic go(input logic we, input logic [16:0] a, input logic [15:0] d,
                      input logic ube, output logic [15:0] q, output int w);
        {low_cnt, req_cnt, req_busy} = 0;
        {c_we, c_addr, c_wdata, c_be} = 'x;
        host.access(we, a, d, ube, q, w);
        if (ck(w >= 20)) fail("hold-off never released");
    endtask : go

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_write;
        logic [15:0] q;
        int w;
        go(1'b1, 17'h1fffe, 16'ha5c3, 1'b0, q, w);
        if (ck(c_we !== 1'b1 || c_addr !== 17'h1fffe)) fail("write address");
        if (ck(c_wdata !== 16'ha5c3)) fail("write data");
        if (ck(c_be !== 2'h3)) fail("write lanes");
        if (ck(low_cnt == 0 || hold_n !== 1'b1)) fail("hold-off");
    endtask : s_write
    task automatic s_byte;
        logic [15:0] q;
        int w;
        @(negedge mclk);
        {dir, status} = 2'b00;
        go(1'b1, 17'h00002, 16'h005a, 1'b1, q, w);
        if (ck(c_be !== 2'h1 || c_wdata !== 16'h005a)) fail("byte write");
        @(negedge mclk);
        {dir, status} = 2'b11;
    endtask : s_byte
    task automatic s_read(input logic [15:0] exp);
        logic [15:0] q;
        int w;
        ack_lat = 3;
        go(1'b0, 17'h00101, 16'h0000, 1'b0, q, w);
        if (ck(q !== exp || c_we !== 1'b0)) fail("read data");
        if (ck(c_addr !== 17'h00101)) fail("read address");
        repeat (6) @(negedge mclk);
        if (ck(oe_n !== 1'b1)) fail("data not floated");
        ack_lat = 0;
    endtask : s_read
    task automatic s_refresh;
        logic [15:0] q;
        int w;
        @(negedge mclk);
        busy = 1'b1;
        fork
            begin
                repeat (40) @(negedge mclk);
                busy = 1'b0;
            end
            go(1'b1, 17'h00010, 16'h0f0f, 1'b0, q, w);
        join
        if (ck(req_busy != 0 || c_wdata !== 16'h0f0f)) fail("refresh clash");
        if (ck(low_cnt < 20 || w < 2)) fail("no wait state");
    endtask : s_refresh
    task automatic s_big;
        logic [15:0] q;
        int w;
        do_reset(3'h7, 1'b1, 1'b1);
        if (ck(big !== 1'b1 || mode_ok !== 1'b1)) fail("strap capture");
        go(1'b1, 17'h00001, 16'h1234, 1'b0, q, w);
        if (ck(c_wdata !== 16'h3412 || c_be !== 2'h1)) fail("big endian write");
        rd_word = 16'hbeef;
        s_read(16'hefbe);
    endtask : s_big
    task automatic s_bad;
        logic [15:0] q;
        int w;
        logic [3:0] cfg [2] = '{4'hd, 4'he};
        foreach (cfg[i]) begin
            do_reset(cfg[i][3:1], cfg[i][0], 1'b0);
            if (ck(mode_ok !== 1'b0)) fail("mode accepted");
            go(1'b1, 17'h00004, 16'h1111, 1'b0, q, w);
            if (ck(req_cnt != 0 || low_cnt != 0)) fail("access in bad mode");
        end
    endtask : s_bad

    initial begin
        #100000;
        fail("watchdog expired");
        close_out();
    end
    initial begin
        do_reset(3'h7, 1'b1, 1'b0);
        if (ck(mode_ok !== 1'b1 || big !== 1'b0)) fail("little endian straps");
        s_write();
        s_byte();
        rd_word = 16'h1234;
        s_read(16'h1234);
        s_refresh();
        s_big();
        s_bad();
        close_out();
    end
endmodule : generic_host_bus_port_test

`default_nettype wire
